// *** shared/pscg_pkg.sv ***
package pscg_pkg;

   // ----------------------------------------------------------------
   // register map, byte addresses on the 32-bit bus
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_OSC_CTL = 8'h00;
   localparam logic [7:0] OFS_CLK_DIV = 8'h04;
   localparam logic [7:0] OFS_GATE_ONE = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int NEXT_OSC_LSB = 8;
   localparam int COSC_LSB = 12;
   localparam int IRQ_RETURN_BIT = 15;
   localparam int DOZE_LSB = 12;
   localparam int DOZE_EN_BIT = 11;
   localparam logic [2:0] NEXT_OSC_RESET = 3'h0;
   localparam logic [2:0] DOZE_RESET = 3'h0;
   localparam logic [15:0] GATE_RESET = 16'h0000;
   // bits 8 and 2 are unimplemented and read zero
   localparam logic [15:0] GATE_WMASK = 16'hfefb;
   localparam logic [15:0] PRESENT_DEFAULT = 16'hfefb;

   // ----------------------------------------------------------------
   // timing and bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0] WAKE_CYCLES = 2'h2;
   localparam int DOZE_CNT_W = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_RUN   = 5'h01,
      ST_ENTER = 5'h02,
      ST_FULL  = 5'h04,
      ST_IDLE  = 5'h08,
      ST_WAKE  = 5'h10
   } pscg_state_e_t;

   typedef struct packed {
      pscg_state_e_t st;
      logic full_sel;
      logic [2:0] next_osc;
      logic [2:0] cur_osc;
      logic irq_return;
      logic [2:0] doze_ratio;
      logic doze_en;
      logic [15:0] gate;
      logic [15:0] gate_eff;
      logic [DOZE_CNT_W-1:0] doze_cnt;
      logic [1:0] wake_cnt;
      logic wdt_clr;
      logic cpu_en;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pscg_regs_t;

endpackage

// *** logic/pscg_top.sv ***
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pscg_top #(
   parameter int ADDR_W = 8,
   parameter logic [15:0] PRESENT_MASK = pscg_pkg::PRESENT_DEFAULT
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // configuration levels
   input wire logic cfg_clock_locked,
   input wire logic cfg_watchdog_en,
   input wire logic cfg_fail_safe_en,
   // cpu side
   input wire logic halt_req,
   input wire logic halt_full,
   input wire logic irq_pending,
   input wire logic watchdog_timeout,
   output logic cpu_clk_en,
   output logic watchdog_clear,
   // clock sources
   output logic [2:0] sys_osc_select,
   output logic sys_osc_run,
   output logic low_power_rc_run,
   output logic fail_safe_monitor_run,
   // peripherals
   output logic periph_sys_clk_en,
   output logic [15:0] periph_clk_en,
   output logic [15:0] periph_reg_en
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   pscg_pkg::pscg_regs_t r;
   pscg_pkg::pscg_regs_t r_nxt;

   logic [ADDR_W-1:0] ofs_osc;
   logic [ADDR_W-1:0] ofs_div;
   logic [ADDR_W-1:0] ofs_gate;
   logic [ADDR_W-1:0] ofs_stat;
   logic wr_take;
   logic rd_take;
   logic wake_evt;
   logic in_full;
   // local copy of the divider width, so casts stay plain
   localparam int DZ_W = pscg_pkg::DOZE_CNT_W;
   logic [DZ_W-1:0] doze_top;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // offsets sized to the bus address width
   assign ofs_osc = ADDR_W'(pscg_pkg::OFS_OSC_CTL);
   assign ofs_div = ADDR_W'(pscg_pkg::OFS_CLK_DIV);
   assign ofs_gate = ADDR_W'(pscg_pkg::OFS_GATE_ONE);
   assign ofs_stat = ADDR_W'(pscg_pkg::OFS_STATUS);

   // address and data are taken in the same edge, one write in flight
   assign wr_take = s_axi_awvalid & s_axi_wvalid & ~r.bvalid;
   assign rd_take = s_axi_arvalid & ~r.rvalid;
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign s_axi_arready = rd_take;

   // any enabled interrupt or timeout wakes; reset wakes by itself
   assign wake_evt = irq_pending | watchdog_timeout;
   assign in_full = (r.st == pscg_pkg::ST_FULL);

   // ratio code n gives a wrap count of two to the n minus one
   assign doze_top = DZ_W'((8'h01 << r.doze_ratio) - 8'h01);

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      r_nxt = r;
      r_nxt.wdt_clr = 1'b0;
      r_nxt.cpu_en = 1'b0;

      // gate bits act one cycle after they are written
      r_nxt.gate_eff = r.gate;

      // oscillator follows the selection unless the configuration is locked;
      // while fully halted the source is frozen so wake reuses it
      if (!cfg_clock_locked && !in_full) begin
         r_nxt.cur_osc = r.next_osc;
      end

      // power state sequence
      case (r.st)
         pscg_pkg::ST_RUN: begin
            if (halt_req) begin
               // operand of the halt request picks the kind of halt
               r_nxt.full_sel = halt_full;
               r_nxt.st = pscg_pkg::ST_ENTER;
            end
         end
         pscg_pkg::ST_ENTER: begin
            // interrupts seen here are not acted on until entry completes
            r_nxt.wdt_clr = r.full_sel ? cfg_watchdog_en : 1'b1;
            r_nxt.st = r.full_sel ? pscg_pkg::ST_FULL : pscg_pkg::ST_IDLE;
         end
         pscg_pkg::ST_FULL, pscg_pkg::ST_IDLE: begin
            // a level still pending from entry wakes at once
            if (wake_evt) begin
               r_nxt.st = pscg_pkg::ST_WAKE;
               r_nxt.wake_cnt = pscg_pkg::WAKE_CYCLES;
            end
         end
         pscg_pkg::ST_WAKE: begin
            // clock is back; hold execution off for the restart delay
            r_nxt.wake_cnt = r.wake_cnt - 2'h1;
            if (r.wake_cnt == 2'h1) begin
               r_nxt.st = pscg_pkg::ST_RUN;
            end
         end
         default: begin
            r_nxt.st = pscg_pkg::ST_RUN;
         end
      endcase

      // doze divider: peripherals keep the full rate, the cpu gets one
      // enable per wrap so both stay on the same edges
      if (r_nxt.st == pscg_pkg::ST_RUN && r.st == pscg_pkg::ST_RUN) begin
         if (r.doze_en) begin
            r_nxt.cpu_en = (r.doze_cnt == doze_top);
            r_nxt.doze_cnt = (r.doze_cnt >= doze_top) ? '0 : r.doze_cnt + 1'b1;
         end else begin
            r_nxt.cpu_en = 1'b1;
            r_nxt.doze_cnt = '0;
         end
      end else begin
         // halted cpu gets no clock; divider restarts cleanly
         r_nxt.doze_cnt = '0;
      end

      // write channel
      if (wr_take) begin
         r_nxt.bvalid = 1'b1;
         r_nxt.bresp = pscg_pkg::RESP_OKAY;
         if (s_axi_awaddr == ofs_osc) begin
            if (s_axi_wstrb[1]) begin
               r_nxt.next_osc = s_axi_wdata[pscg_pkg::NEXT_OSC_LSB +: 3];
            end
         end else if (s_axi_awaddr == ofs_div) begin
            if (s_axi_wstrb[1]) begin
               r_nxt.irq_return = s_axi_wdata[pscg_pkg::IRQ_RETURN_BIT];
               r_nxt.doze_ratio = s_axi_wdata[pscg_pkg::DOZE_LSB +: 3];
               r_nxt.doze_en = s_axi_wdata[pscg_pkg::DOZE_EN_BIT];
            end
         end else if (s_axi_awaddr == ofs_gate) begin
            // unimplemented bits never store a one
            if (s_axi_wstrb[0]) begin
               r_nxt.gate[7:0] = s_axi_wdata[7:0] & pscg_pkg::GATE_WMASK[7:0];
            end
            if (s_axi_wstrb[1]) begin
               r_nxt.gate[15:8] = s_axi_wdata[15:8] & pscg_pkg::GATE_WMASK[15:8];
            end
         end else if (s_axi_awaddr != ofs_stat) begin
            r_nxt.bresp = pscg_pkg::RESP_SLVERR;
         end
      end else if (r.bvalid && s_axi_bready) begin
         r_nxt.bvalid = 1'b0;
      end

      // interrupt ends doze after any software write of the same cycle,
      // so a stale enable never outlives the interrupt
      if (r.irq_return && irq_pending) begin
         r_nxt.doze_en = 1'b0;
      end

      // read channel
      if (rd_take) begin
         r_nxt.rvalid = 1'b1;
         r_nxt.rresp = pscg_pkg::RESP_OKAY;
         r_nxt.rdata = '0;
         if (s_axi_araddr == ofs_osc) begin
            r_nxt.rdata[pscg_pkg::NEXT_OSC_LSB +: 3] = r.next_osc;
            r_nxt.rdata[pscg_pkg::COSC_LSB +: 3] = r.cur_osc;
         end else if (s_axi_araddr == ofs_div) begin
            r_nxt.rdata[pscg_pkg::IRQ_RETURN_BIT] = r.irq_return;
            r_nxt.rdata[pscg_pkg::DOZE_LSB +: 3] = r.doze_ratio;
            r_nxt.rdata[pscg_pkg::DOZE_EN_BIT] = r.doze_en;
         end else if (s_axi_araddr == ofs_gate) begin
            r_nxt.rdata[15:0] = r.gate;
         end else if (s_axi_araddr == ofs_stat) begin
            // live power state, one-hot, and whether the cpu is clocked
            r_nxt.rdata[4:0] = r.st;
            r_nxt.rdata[8] = r.cpu_en;
         end else begin
            r_nxt.rresp = pscg_pkg::RESP_SLVERR;
         end
      end else if (r.rvalid && s_axi_rready) begin
         r_nxt.rvalid = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // reset also wakes from either halt
         r.st <= pscg_pkg::ST_RUN;
         r.full_sel <= 1'b0;
         r.next_osc <= pscg_pkg::NEXT_OSC_RESET;
         r.cur_osc <= pscg_pkg::NEXT_OSC_RESET;
         r.irq_return <= 1'b0;
         r.doze_ratio <= pscg_pkg::DOZE_RESET;
         r.doze_en <= 1'b0;
         r.gate <= pscg_pkg::GATE_RESET;
         r.gate_eff <= pscg_pkg::GATE_RESET;
         r.doze_cnt <= '0;
         r.wake_cnt <= 2'h0;
         r.wdt_clr <= 1'b0;
         r.cpu_en <= 1'b0;
         r.bvalid <= 1'b0;
         r.bresp <= pscg_pkg::RESP_OKAY;
         r.rvalid <= 1'b0;
         r.rdata <= 32'h0000_0000;
         r.rresp <= pscg_pkg::RESP_OKAY;
      end else begin
         r <= r_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;

   assign cpu_clk_en = r.cpu_en;
   assign watchdog_clear = r.wdt_clr;
   assign sys_osc_select = r.cur_osc;

   // clock sources by power state
   assign sys_osc_run = ~in_full;
   assign fail_safe_monitor_run = cfg_fail_safe_en & ~in_full;
   assign low_power_rc_run = in_full ? cfg_watchdog_en
                                     : (cfg_watchdog_en | cfg_fail_safe_en);

   // peripheral clocks: full rate in doze and cpu-only halt, off in full halt
   assign periph_sys_clk_en = ~in_full;

   // per-peripheral enables; a gate bit stops register access and clock, full halt stops only the clock
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_gate
         assign periph_reg_en[gi] = PRESENT_MASK[gi] & ~r.gate_eff[gi];
         assign periph_clk_en[gi] = PRESENT_MASK[gi] & ~r.gate_eff[gi] & ~in_full;
      end
   endgenerate

endmodule

// *** tb/pscg_assertions.sv ***
`timescale 1ns/1ps
module pscg_assertions #(
   parameter int ADDR_W = 8,
   parameter logic [15:0] PRESENT_MASK = pscg_pkg::PRESENT_DEFAULT
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register writes
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   // cpu side
   input wire logic cfg_watchdog_en,
   input wire logic halt_req,
   input wire logic halt_full,
   input wire logic irq_pending,
   input wire logic cpu_clk_en,
   input wire logic watchdog_clear,
   // clocks and peripherals
   input wire logic [2:0] sys_osc_select,
   input wire logic sys_osc_run,
   input wire logic low_power_rc_run,
   input wire logic fail_safe_monitor_run,
   input wire logic periph_sys_clk_en,
   input wire logic [15:0] periph_clk_en,
   input wire logic [15:0] periph_reg_en
);
   // --------------------------------------------------------------
   // halt, wake and gating checks
   // --------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // a high cpu_clk_en marks the run state, so only taken requests match
   sequence full_req_s;
      halt_req && halt_full && cpu_clk_en;
   endsequence
   sequence idle_req_s;
      halt_req && !halt_full && cpu_clk_en;
   endsequence
   // cpu-only halt reached: watchdog cleared, clocks still running
   sequence idle_on_s;
      watchdog_clear && sys_osc_run && periph_sys_clk_en;
   endsequence
   // oscillator back at once, cpu held three cycles, then clocked
   sequence wake_s;
      sys_osc_run ##0 (!cpu_clk_en) [*3] ##1 cpu_clk_en;
   endsequence
   // data captured at the take edge; shows two edges later
   property gate_delay_p;
      logic [15:0] d;
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wstrb == 4'h3
       && s_axi_awaddr == ADDR_W'(pscg_pkg::OFS_GATE_ONE), d = s_axi_wdata[15:0])
      |=> $stable(periph_reg_en) ##1 periph_reg_en == (PRESENT_MASK & ~(d & pscg_pkg::GATE_WMASK));
   endproperty

   full_entry_a: assert property (full_req_s |=> !cpu_clk_en ##1 (!sys_osc_run && !periph_sys_clk_en))
      else $error("full halt kept clocks");
   wdt_full_a: assert property (full_req_s ##0 cfg_watchdog_en |=> ##1 watchdog_clear)
      else $error("no watchdog clear on full halt");
   idle_entry_a: assert property (idle_req_s |=> !cpu_clk_en ##1 idle_on_s)
      else $error("cpu-only halt entry wrong");
   monitor_off_a: assert property (!sys_osc_run |-> !fail_safe_monitor_run)
      else $error("monitor runs in full halt");
   rc_full_a: assert property (!sys_osc_run && cfg_watchdog_en |-> low_power_rc_run)
      else $error("rc stopped in full halt");
   wake_full_a: assert property (!sys_osc_run && irq_pending |=> wake_s)
      else $error("wake sequence wrong");
   src_hold_a: assert property (!sys_osc_run |-> $stable(sys_osc_select))
      else $error("source changed in halt");
   gate_mask_a: assert property (periph_clk_en == (periph_reg_en & {16{periph_sys_clk_en}})
      && (periph_reg_en & ~PRESENT_MASK) == 16'h0000)
      else $error("peripheral enables inconsistent");
   gate_delay_a: assert property (gate_delay_p)
      else $error("gate change timing wrong");
endmodule

bind pscg_top pscg_assertions #(.ADDR_W(ADDR_W), .PRESENT_MASK(PRESENT_MASK)) u_chk (.*);

// *** tb/pscg_cpu_model.sv ***
`timescale 1ns/1ps
module pscg_cpu_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bench commands and cpu status
   input wire logic cmd_halt,
   input wire logic cmd_full,
   input wire logic cmd_irq,
   input wire logic cpu_clk_en,
   // requests to the block
   output logic halt_req,
   output logic halt_full,
   output logic irq_pending
);
   logic served_r;
   // operand toggles when idle so nothing leans on a stale value;
   // the interrupt stays until the handler ran two cpu cycles
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         halt_req <= 1'b0;
         halt_full <= 1'b0;
         irq_pending <= 1'b0;
         served_r <= 1'b0;
      end else begin
         halt_req <= cmd_halt;
         halt_full <= cmd_halt ? cmd_full : ~halt_full;
         if (cmd_irq) begin
            irq_pending <= 1'b1;
            served_r <= 1'b0;
         end else if (irq_pending && cpu_clk_en) begin
            served_r <= 1'b1;
            irq_pending <= !served_r;
         end
      end
   end
endmodule

// *** tb/test_power_save_clock_gating.sv ***
`timescale 1ns/1ps
module test_power_save_clock_gating;
   // --------------------------------------------------------------
   // stimulus, instances and shared tasks
   // --------------------------------------------------------------
   localparam logic [15:0] PM = pscg_pkg::PRESENT_DEFAULT;
   localparam logic [1:0] OK = pscg_pkg::RESP_OKAY;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'h3;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic cfg_clock_locked = 1'b0, cfg_watchdog_en = 1'b0, cfg_fail_safe_en = 1'b0, watchdog_timeout = 1'b0;
   logic cmd_halt = 1'b0, cmd_full = 1'b0, cmd_irq = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic halt_req, halt_full, irq_pending, cpu_clk_en, watchdog_clear;
   logic [2:0] sys_osc_select, sel;
   logic sys_osc_run, low_power_rc_run, fail_safe_monitor_run, periph_sys_clk_en;
   logic [15:0] periph_clk_en, periph_reg_en;
   int n_mismatch = 0;
   int checked = 0;

   pscg_top dut (.*);
   pscg_cpu_model cpu (.*);

   initial begin
      forever #5 aclk = ~aclk;
   end

   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // wait for a level sampled at a rising edge; only the watchdog ends a hang
   task automatic wait_hi(ref logic s);
      do begin
         @(posedge aclk);
      end while (s !== 1'b1);
      chk(s === 1'b1, "handshake missing");
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      wait_hi(s_axi_awready);
      chk(s_axi_wready === 1'b1, "write data not taken");
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      wait_hi(s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp === er, "write response");
      // let an edge pass so a following call never re-raises bready at once
      @(posedge aclk);
   endtask
   task automatic axi_read(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      wait_hi(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      wait_hi(s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      // let an edge pass so a following call never re-raises rready at once
      @(posedge aclk);
   endtask
   task automatic halt(input logic full, input logic irq);
      cmd_halt <= 1'b1;
      cmd_full <= full;
      cmd_irq <= irq;
      @(posedge aclk);
      cmd_halt <= 1'b0;
      cmd_irq <= 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic test_regs();
      chk(periph_clk_en === PM, "not open after reset");
      axi_read(pscg_pkg::OFS_CLK_DIV);
      chk(rd[15:11] === 5'h00, "divider reset");
      axi_read(8'h10);
      chk(rs === pscg_pkg::RESP_SLVERR, "unmapped read");
      axi_write(8'h14, 32'h0, pscg_pkg::RESP_SLVERR);
      axi_write(pscg_pkg::OFS_GATE_ONE, 32'h0000ffff, OK);
      axi_read(pscg_pkg::OFS_GATE_ONE);
      chk(rd[15:0] === 16'hfefb, "bits 8, 2 not zero");
      chk(periph_reg_en === 16'h0000 && periph_clk_en === 16'h0000, "gated still on");
      axi_write(pscg_pkg::OFS_GATE_ONE, 32'h00000003, OK);
      cyc(2);
      chk(periph_clk_en === 16'hfef8, "can/adc gates");
      axi_write(pscg_pkg::OFS_GATE_ONE, 32'h0, OK);
      cyc(2);
      chk(periph_clk_en === PM, "not re-enabled");
      axi_write(pscg_pkg::OFS_OSC_CTL, 32'h00000500, OK);
      cyc(8);
      chk(sys_osc_select === 3'h5, "unlocked select");
      cfg_clock_locked <= 1'b1;
      axi_write(pscg_pkg::OFS_OSC_CTL, 32'h00000300, OK);
      cyc(8);
      chk(sys_osc_select === 3'h5, "locked select moved");
      $display("test_regs done");
   endtask
   task automatic test_halts();
      cfg_watchdog_en <= 1'b1;
      sel = sys_osc_select;
      halt(1'b1, 1'b0);
      cyc(20);
      chk(sys_osc_run === 1'b0 && cpu_clk_en === 1'b0 && periph_clk_en === 16'h0, "full halt");
      chk(low_power_rc_run === 1'b1 && fail_safe_monitor_run === 1'b0, "rc/monitor");
      halt(1'b0, 1'b1);
      wait_hi(cpu_clk_en);
      chk(sys_osc_select === sel, "source changed");
      cyc(4);
      cfg_watchdog_en <= 1'b0;
      cfg_fail_safe_en <= 1'b1;
      halt(1'b0, 1'b0);
      cyc(10);
      chk(cpu_clk_en === 1'b0 && sys_osc_run === 1'b1 && periph_clk_en === PM, "cpu-only halt");
      chk(low_power_rc_run === 1'b1, "rc off in idle");
      watchdog_timeout <= 1'b1;
      @(posedge aclk);
      watchdog_timeout <= 1'b0;
      // timeout seen at the last edge; cpu held three cycles, clocked on the fourth
      cyc(3);
      chk(cpu_clk_en === 1'b0, "resumed early");
      cyc(1);
      chk(cpu_clk_en === 1'b1, "no wake on timeout");
      cfg_watchdog_en <= 1'b1;
      halt(1'b1, 1'b1);
      wait_hi(watchdog_clear);
      wait_hi(cpu_clk_en);
      $display("test_halts done");
   endtask
   task automatic test_doze();
      int n, cnt;
      for (n = 0; n < 9; n++) begin
         axi_write(pscg_pkg::OFS_CLK_DIV, {16'h0, 1'b0, 3'(n), n < 8, 11'h0}, OK);
         cyc(130);
         cnt = 0;
         repeat (256) begin
            @(posedge aclk);
            cnt += (cpu_clk_en === 1'b1);
         end
         chk(cnt == (n < 8 ? 256 >> n : 256), "doze rate");
         chk(periph_clk_en === PM, "peripherals slowed");
      end
      axi_write(pscg_pkg::OFS_CLK_DIV, {16'h0, 1'b1, 3'h3, 1'b1, 11'h0}, OK);
      halt(1'b0, 1'b1);
      // the handler must consume the interrupt before the next divider write,
      // else the pending request clears the freshly written enable again
      cyc(12);
      axi_read(pscg_pkg::OFS_CLK_DIV);
      chk(rd[15:11] === 5'b10110, "doze kept on irq");
      axi_write(pscg_pkg::OFS_CLK_DIV, {16'h0, 1'b0, 3'h3, 1'b1, 11'h0}, OK);
      halt(1'b0, 1'b1);
      cyc(4);
      axi_read(pscg_pkg::OFS_CLK_DIV);
      chk(rd[15:11] === 5'b00111, "doze left without return");
      $display("test_doze done");
   endtask

   initial begin
      cyc(2);
      aresetn <= 1'b1;
      @(posedge aclk);
      test_regs();
      test_halts();
      test_doze();
      tally_and_finish();
   end
   initial begin
      #200000;
      n_mismatch++;
      $display("unexpected at %0t: run too long", $time);
      tally_and_finish();
   end
endmodule
